//--- core/csfc_map.vh
`ifndef CSFC_MAP_VH
`define CSFC_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CSFC_REG_CLK_IF_CFG     7'h04
`define CSFC_REG_GEN_CFG        7'h05
`define CSFC_REG_AIN_PCHG_1     7'h11
`define CSFC_REG_AIN_PCHG_2     7'h12
`define CSFC_REG_REF_POS_PCHG   7'h13
`define CSFC_REG_REF_NEG_PCHG   7'h14
`define CSFC_REG_DEV_STATUS     7'h16

// ****************************************************************
// field positions
// ****************************************************************
`define CSFC_LVDS_EN_BIT        3
`define CSFC_CM_EN_BIT          4
`define CSFC_CM_LVL_LSB         0
`define CSFC_CM_LVL_MSB         1
`define CSFC_ST_CLK_ERR_BIT     0
`define CSFC_ST_EXT_CLK_BIT     1
`define CSFC_ST_SERIAL_BIT      2
`define CSFC_ST_CLK_SEL_BIT     3

// ****************************************************************
// reset values
// ****************************************************************
`define CSFC_RST_CLK_IF_CFG     8'h00
`define CSFC_RST_GEN_CFG        8'h10
`define CSFC_RST_AIN_PCHG       4'hF
`define CSFC_RST_REF_PCHG       8'h00
`define CSFC_CM_LVL_HALF        2'h0

// ****************************************************************
// timing
// ****************************************************************
`define CSFC_CLK_PERIOD_NS      5
`define CSFC_STARTUP_NS         1000
`define CSFC_STARTUP_CYC \
  ((`CSFC_STARTUP_NS + `CSFC_CLK_PERIOD_NS - 1) / `CSFC_CLK_PERIOD_NS)
`define CSFC_MCLK_MIN_KHZ       1150
`define CSFC_CHK_WIN_CYC        4096
// edges a 1.15 MHz clock shows in the window, rounded down for margin
`define CSFC_CHK_THRESH \
  ((`CSFC_MCLK_MIN_KHZ * `CSFC_CHK_WIN_CYC * `CSFC_CLK_PERIOD_NS) / 1000000)
`define CSFC_MOD_DIV            8

`endif

//--- core/csfc_mclk_check.v
`timescale 1ns/100ps
`include "csfc_map.vh"

// ****************************************************************
// master clock edge counter over a fixed window
// ****************************************************************
module csfc_mclk_check #(
  parameter WIN_CYC = `CSFC_CHK_WIN_CYC,
  parameter THRESH  = `CSFC_CHK_THRESH,
  parameter CW      = 13
) (
  input  wire clk_sys_i,
  input  wire nrst_i,
  input  wire start_i,
  input  wire mclk_i,
  output reg  done_o,
  output reg  pass_o
);

  localparam integer  WIN_LAST_I = WIN_CYC - 1;
  localparam integer  THR_I      = THRESH;
  localparam [CW-1:0] WIN_LAST   = WIN_LAST_I[CW-1:0];
  localparam [CW-1:0] THR        = THR_I[CW-1:0];

  reg          mclk_q_ff;
  reg          busy_ff;
  reg [CW-1:0] win_ff;
  reg [CW-1:0] edges_ff;
  wire         fall;

  assign fall = mclk_q_ff & ~mclk_i; // [RQ2]

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_q_ff <= 1'b0;
      busy_ff   <= 1'b0;
      win_ff    <= {CW{1'b0}};
      edges_ff  <= {CW{1'b0}};
      done_o    <= 1'b0;
      pass_o    <= 1'b0;
    end else begin
      mclk_q_ff <= mclk_i;
      done_o    <= 1'b0;
      if (start_i && !busy_ff) begin
        busy_ff  <= 1'b1;
        win_ff   <= {CW{1'b0}};
        edges_ff <= {CW{1'b0}};
      end else if (busy_ff) begin
        // saturate so a very fast clock cannot wrap to a fail
        if (fall && edges_ff != {CW{1'b1}}) begin
          edges_ff <= edges_ff + {{(CW-1){1'b0}}, 1'b1};
        end
        if (win_ff == WIN_LAST) begin
          busy_ff <= 1'b0;
          done_o  <= 1'b1;
          pass_o  <= (edges_ff >= THR); // [RQ2] [RQ21]
        end else begin
          win_ff <= win_ff + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

//--- core/csfc_ctrl.v
`timescale 1ns/100ps
`include "csfc_map.vh"

// How it works
// [RQ1] run on internal oscillator; hand over to master clock after start-up
// [RQ2] master clock valid if falling edges in window meet 1.15 MHz threshold
// [RQ3] failed check keeps oscillator, flags header error and status bit
// [RQ4] clock error stops conversion data; only reset leaves it
// [RQ5] select strap low at power-up: single-ended clock, companion grounded
// [RQ6] select strap high at power-up: crystal or differential clock
// [RQ7] differential LVDS clock only in serial mode, enabled by bit 3 of 0x04
// [RQ8] inputs sampled at twice modulator frequency derived from master clock
// [RQ9] bypass switches open first quarter of each phase, closed after
// [RQ10] input precharge buffers drive sampling capacitors by default
// [RQ11] per-channel input precharge enables live in 0x11 and 0x12
// [RQ12] pin mode forces every input precharge buffer on
// [RQ13] pin mode: common-mode output on at half supply
// [RQ14] serial mode: common-mode enable and level come from 0x05
// [RQ15] channel 0 standby turns the common-mode output off
// [RQ16] each converter has positive and negative reference buffer enables
// [RQ17] pin mode keeps reference buffers off; serial mode lets host choose
// [RQ18] host should enable only positive reference buffers on unipolar supply
// [RQ19] control mode strap is taken once at power-up
// [RQ20] enable bit one means buffer on; input enables reset to one
// [RQ21] check window and threshold are parameters with margin

module csfc_ctrl #(
  parameter STARTUP_CYC = `CSFC_STARTUP_CYC,
  parameter WIN_CYC     = `CSFC_CHK_WIN_CYC,
  parameter THRESH      = `CSFC_CHK_THRESH,
  parameter MOD_DIV     = `CSFC_MOD_DIV
) (
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  input  wire       mclk_i,
  input  wire       clk_sel_i,
  input  wire       ctrl_serial_i,
  input  wire       ch0_standby_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [6:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  output reg        serial_mode_o,
  output reg        ext_clk_active_o,
  output reg        clk_err_o,
  output reg        hdr_clk_err_o,
  output reg        conv_en_o,
  output reg        cmos_clk_sel_o,
  output reg        xtal_diff_sel_o,
  output reg        lvds_en_o,
  output reg        sampling_phase_o,
  output reg        bypass_switch_o,
  output reg  [7:0] ain_pchg_en_o,
  output reg  [7:0] ref_pos_pchg_en_o,
  output reg  [7:0] ref_neg_pchg_en_o,
  output reg        common_mode_output_en_o,
  output reg  [1:0] common_mode_output_lvl_o
);

  // ****************************************************************
  // states and derived constants
  // ****************************************************************
  localparam [1:0] ST_STARTUP = 2'h0;
  localparam [1:0] ST_CHECK   = 2'h1;
  localparam [1:0] ST_RUN     = 2'h2;
  localparam [1:0] ST_CLKERR  = 2'h3;

  localparam integer SU_LAST_I = STARTUP_CYC - 1;
  // one sampling phase is half a modulator period in master clocks
  localparam integer PH_LEN    = MOD_DIV / 2;
  localparam integer PH_LAST_I = PH_LEN - 1;
  localparam integer PH_OPEN_I = PH_LEN / 4;
  localparam [15:0]  SU_LAST   = SU_LAST_I[15:0];
  localparam [7:0]   PH_LAST   = PH_LAST_I[7:0];
  localparam [7:0]   PH_OPEN   = PH_OPEN_I[7:0];

  // ****************************************************************
  // state
  // ****************************************************************
  reg        strap_done_ff;
  reg        serial_ff;
  reg        clk_sel_ff;
  reg [1:0]  state_ff;
  reg [1:0]  nxt_state;
  reg [15:0] su_cnt_ff;
  reg        chk_start_ff;
  reg        mclk_q_ff;
  reg [7:0]  ph_cnt_ff;
  reg        ph_ff;

  reg [7:0]  clk_if_cfg_ff;
  reg [7:0]  gen_cfg_ff;
  reg [3:0]  ain_pchg_1_ff;
  reg [3:0]  ain_pchg_2_ff;
  reg [7:0]  ref_pos_ff;
  reg [7:0]  ref_neg_ff;

  wire       chk_done;
  wire       chk_pass;
  wire       mclk_rise;
  wire [7:0] status;

  reg [7:0]  nxt_ain;
  reg [7:0]  nxt_ref_pos;
  reg [7:0]  nxt_ref_neg;
  reg        nxt_cm_en;
  reg [1:0]  nxt_cm_lvl;

  // ****************************************************************
  // register read decode
  // ****************************************************************
  function [7:0] rd_mux;
    input [6:0] addr;
    input [7:0] clk_if;
    input [7:0] gen;
    input [3:0] ain1;
    input [3:0] ain2;
    input [7:0] rpos;
    input [7:0] rneg;
    input [7:0] st;
    begin
      case (addr)
        `CSFC_REG_CLK_IF_CFG:   rd_mux = clk_if;
        `CSFC_REG_GEN_CFG:      rd_mux = gen;
        `CSFC_REG_AIN_PCHG_1:   rd_mux = {4'h0, ain1};
        `CSFC_REG_AIN_PCHG_2:   rd_mux = {4'h0, ain2};
        `CSFC_REG_REF_POS_PCHG: rd_mux = rpos;
        `CSFC_REG_REF_NEG_PCHG: rd_mux = rneg;
        `CSFC_REG_DEV_STATUS:   rd_mux = st;
        default:                rd_mux = 8'h00;
      endcase
    end
  endfunction

  // ****************************************************************
  // power-up straps
  // ****************************************************************
  // straps are caught on the first edge after release, never at reset
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_ff <= 1'b0;
      serial_ff     <= 1'b0;
      clk_sel_ff    <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      serial_ff     <= ctrl_serial_i; // [RQ19]
      clk_sel_ff    <= clk_sel_i; // [RQ5] [RQ6]
    end
  end

  // ****************************************************************
  // clock handover sequence
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STARTUP: begin
        if (strap_done_ff && su_cnt_ff == SU_LAST) begin
          nxt_state = ST_CHECK; // [RQ1]
        end
      end
      ST_CHECK: begin
        if (chk_done) begin
          nxt_state = chk_pass ? ST_RUN : ST_CLKERR; // [RQ1] [RQ3]
        end
      end
      ST_RUN:    nxt_state = ST_RUN;
      ST_CLKERR: nxt_state = ST_CLKERR; // [RQ4]
      default:   nxt_state = ST_STARTUP;
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff     <= ST_STARTUP;
      su_cnt_ff    <= 16'h0000;
      chk_start_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      chk_start_ff <= (state_ff == ST_STARTUP) && (nxt_state == ST_CHECK);
      if (state_ff == ST_STARTUP && strap_done_ff && su_cnt_ff != SU_LAST) begin
        su_cnt_ff <= su_cnt_ff + 16'h0001;
      end
    end
  end

  csfc_mclk_check #(
    .WIN_CYC (WIN_CYC),
    .THRESH  (THRESH),
    .CW      (13)
  ) u_check (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (chk_start_ff),
    .mclk_i    (mclk_i),
    .done_o    (chk_done),
    .pass_o    (chk_pass)
  );

  // ****************************************************************
  // sampling phase and bypass switch timing
  // ****************************************************************
  assign mclk_rise = mclk_i & ~mclk_q_ff;

  // phases only advance once the master clock owns internal timing
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_q_ff <= 1'b0;
      ph_cnt_ff <= 8'h00;
      ph_ff     <= 1'b0;
    end else begin
      mclk_q_ff <= mclk_i;
      if (state_ff == ST_RUN && mclk_rise) begin
        if (ph_cnt_ff == PH_LAST) begin
          ph_cnt_ff <= 8'h00;
          ph_ff     <= ~ph_ff; // [RQ8]
        end else begin
          ph_cnt_ff <= ph_cnt_ff + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // pin mode only allows register reads, so writes are dropped there
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clk_if_cfg_ff <= `CSFC_RST_CLK_IF_CFG;
      gen_cfg_ff    <= `CSFC_RST_GEN_CFG;
      ain_pchg_1_ff <= `CSFC_RST_AIN_PCHG; // [RQ10] [RQ20]
      ain_pchg_2_ff <= `CSFC_RST_AIN_PCHG; // [RQ10] [RQ20]
      ref_pos_ff    <= `CSFC_RST_REF_PCHG;
      ref_neg_ff    <= `CSFC_RST_REF_PCHG;
      reg_rdata_o   <= 8'h00;
    end else begin
      if (reg_wr_i && serial_ff && strap_done_ff) begin
        case (reg_addr_i)
          `CSFC_REG_CLK_IF_CFG:   clk_if_cfg_ff <= reg_wdata_i; // [RQ7]
          `CSFC_REG_GEN_CFG:      gen_cfg_ff    <= reg_wdata_i; // [RQ14]
          `CSFC_REG_AIN_PCHG_1:   ain_pchg_1_ff <= reg_wdata_i[3:0]; // [RQ11]
          `CSFC_REG_AIN_PCHG_2:   ain_pchg_2_ff <= reg_wdata_i[3:0]; // [RQ11]
          `CSFC_REG_REF_POS_PCHG: ref_pos_ff    <= reg_wdata_i; // [RQ16]
          `CSFC_REG_REF_NEG_PCHG: ref_neg_ff    <= reg_wdata_i; // [RQ16]
          default: ;
        endcase
      end
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux(reg_addr_i, clk_if_cfg_ff, gen_cfg_ff,
                              ain_pchg_1_ff, ain_pchg_2_ff, ref_pos_ff,
                              ref_neg_ff, status);
      end
    end
  end

  assign status = {4'h0, clk_sel_ff, serial_ff,
                   (state_ff == ST_RUN), (state_ff == ST_CLKERR)}; // [RQ3]

  // ****************************************************************
  // front-end enables
  // ****************************************************************
  always @* begin
    if (serial_ff) begin
      nxt_ain     = {ain_pchg_2_ff, ain_pchg_1_ff}; // [RQ11] [RQ20]
      nxt_ref_pos = ref_pos_ff; // [RQ17]
      nxt_ref_neg = ref_neg_ff; // [RQ17]
      nxt_cm_en   = gen_cfg_ff[`CSFC_CM_EN_BIT]; // [RQ14]
      nxt_cm_lvl  = gen_cfg_ff[`CSFC_CM_LVL_MSB:`CSFC_CM_LVL_LSB]; // [RQ14]
    end else begin
      nxt_ain     = 8'hFF; // [RQ12]
      nxt_ref_pos = 8'h00; // [RQ17]
      nxt_ref_neg = 8'h00; // [RQ17]
      nxt_cm_en   = 1'b1; // [RQ13]
      nxt_cm_lvl  = `CSFC_CM_LVL_HALF; // [RQ13]
    end
    // buffer shares channel 0 bias, so standby always wins
    if (ch0_standby_i) begin
      nxt_cm_en = 1'b0; // [RQ15]
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      serial_mode_o            <= 1'b0;
      ext_clk_active_o         <= 1'b0;
      clk_err_o                <= 1'b0;
      hdr_clk_err_o            <= 1'b0;
      conv_en_o                <= 1'b0;
      cmos_clk_sel_o           <= 1'b0;
      xtal_diff_sel_o          <= 1'b0;
      lvds_en_o                <= 1'b0;
      sampling_phase_o         <= 1'b0;
      bypass_switch_o          <= 1'b0;
      ain_pchg_en_o            <= 8'h00;
      ref_pos_pchg_en_o        <= 8'h00;
      ref_neg_pchg_en_o        <= 8'h00;
      common_mode_output_en_o  <= 1'b0;
      common_mode_output_lvl_o <= 2'h0;
    end else begin
      serial_mode_o    <= serial_ff;
      ext_clk_active_o <= (state_ff == ST_RUN); // [RQ1]
      clk_err_o        <= (state_ff == ST_CLKERR); // [RQ3]
      hdr_clk_err_o    <= (state_ff == ST_CLKERR); // [RQ3]
      conv_en_o        <= (state_ff == ST_RUN); // [RQ4]
      cmos_clk_sel_o   <= strap_done_ff & ~clk_sel_ff; // [RQ5]
      xtal_diff_sel_o  <= strap_done_ff & clk_sel_ff; // [RQ6]
      lvds_en_o        <= clk_sel_ff & serial_ff &
                          clk_if_cfg_ff[`CSFC_LVDS_EN_BIT]; // [RQ7]
      sampling_phase_o <= ph_ff; // [RQ8]
      // closed only after the precharge quarter of the phase
      bypass_switch_o  <= (state_ff == ST_RUN) &&
                          (ph_cnt_ff >= PH_OPEN); // [RQ9]
      ain_pchg_en_o            <= nxt_ain;
      ref_pos_pchg_en_o        <= nxt_ref_pos;
      ref_neg_pchg_en_o        <= nxt_ref_neg;
      common_mode_output_en_o  <= nxt_cm_en;
      common_mode_output_lvl_o <= nxt_cm_lvl;
    end
  end

endmodule

//--- bench/csfc_ctrl_props.sv
`timescale 1ns/100ps
module csfc_ctrl_props #(
  parameter STARTUP_CYC = 4,
  parameter WIN_CYC     = 64
) (
  input wire       clk_sys_i,
  input wire       nrst_i,
  input wire       serial_mode_o,
  input wire       ext_clk_active_o,
  input wire       clk_err_o,
  input wire       hdr_clk_err_o,
  input wire       conv_en_o,
  input wire       xtal_diff_sel_o,
  input wire       lvds_en_o,
  input wire       sampling_phase_o,
  input wire       bypass_switch_o,
  input wire [7:0] ain_pchg_en_o,
  input wire [7:0] ref_pos_pchg_en_o,
  input wire [7:0] ref_neg_pchg_en_o
);
  localparam DONE_CYC = STARTUP_CYC + WIN_CYC;
  reg  [15:0] cnt_ff;
  wire        settled = ext_clk_active_o | clk_err_o;

  // cycles since reset release, saturating
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i)
      cnt_ff <= 16'h0000;
    else if (cnt_ff != 16'hFFFF)
      cnt_ff <= cnt_ff + 16'h0001;
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  property p_hdr; hdr_clk_err_o == clk_err_o; endproperty
  a_hdr: assert property (p_hdr)
    else $error("header error flag differs from status");
  property p_sticky; clk_err_o |=> clk_err_o && !ext_clk_active_o;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("clock error left without reset");
  property p_noconv; clk_err_o |-> !conv_en_o && !ext_clk_active_o;
  endproperty
  a_noconv: assert property (p_noconv)
    else $error("conversion allowed in clock error");
  property p_conv; conv_en_o |-> ext_clk_active_o; endproperty
  a_conv: assert property (p_conv)
    else $error("conversion without master clock");
  property p_lvds; lvds_en_o |-> xtal_diff_sel_o && serial_mode_o;
  endproperty
  a_lvds: assert property (p_lvds)
    else $error("differential clock outside serial mode");
  property p_pin; (!serial_mode_o && settled) |-> ain_pchg_en_o == 8'hFF
    && ref_pos_pchg_en_o == 8'h00 && ref_neg_pchg_en_o == 8'h00;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin mode buffer enables wrong");
  property p_byp; $fell(bypass_switch_o) |-> $changed(sampling_phase_o);
  endproperty
  a_byp: assert property (p_byp)
    else $error("bypass opened away from phase start");
  property p_early; cnt_ff < DONE_CYC |-> !settled; endproperty
  a_early: assert property (p_early)
    else $error("clock verdict before check window ended");
  property p_late; cnt_ff == DONE_CYC + 12 |-> settled; endproperty
  a_late: assert property (p_late)
    else $error("no clock verdict after check window");
endmodule

//--- bench/csfc_mclk_src.sv
`timescale 1ns/100ps
// master clock source; parks low when stopped, offset from system edges
module csfc_mclk_src #(
  parameter HALF_NS = 20
) (
  input wire run_i,
  output reg mclk_o
);
  initial begin
    mclk_o = 1'b0;
    #1.3;
    forever begin
      #HALF_NS;
      mclk_o = run_i ? ~mclk_o : 1'b0;
    end
  end
endmodule

//--- bench/csfc_ctrl_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    tests_run = tests_run + 1; \
    if ((g) !== (e)) begin \
      mismatches = mismatches + 1; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module csfc_ctrl_tb;
  localparam STARTUP_CYC = 4;
  localparam WIN_CYC     = 64;
  localparam MDIV        = 8;
  localparam MCLK_CYC    = 8;
  reg        clk_sys_i, nrst_i, mclk_run, clk_sel_i, ctrl_serial_i;
  reg        ch0_standby_i, reg_wr_i, reg_rd_i;
  reg  [6:0] reg_addr_i;
  reg  [7:0] reg_wdata_i;
  wire       mclk_i, serial_mode_o, ext_clk_active_o, clk_err_o;
  wire       hdr_clk_err_o, conv_en_o, cmos_clk_sel_o, xtal_diff_sel_o;
  wire       lvds_en_o, sampling_phase_o, bypass_switch_o;
  wire       common_mode_output_en_o;
  wire [1:0] common_mode_output_lvl_o;
  wire [7:0] reg_rdata_o, ain_pchg_en_o;
  wire [7:0] ref_pos_pchg_en_o, ref_neg_pchg_en_o;
  integer    mismatches, tests_run;

  csfc_mclk_src csfc_mclk_src_inst (.run_i(mclk_run), .mclk_o(mclk_i));
  csfc_ctrl #(.STARTUP_CYC(STARTUP_CYC), .WIN_CYC(WIN_CYC), .THRESH(4),
    .MOD_DIV(MDIV)) csfc_ctrl_inst (.clk_sys_i, .nrst_i, .mclk_i,
    .clk_sel_i, .ctrl_serial_i, .ch0_standby_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .serial_mode_o,
    .ext_clk_active_o, .clk_err_o, .hdr_clk_err_o, .conv_en_o,
    .cmos_clk_sel_o, .xtal_diff_sel_o, .lvds_en_o, .sampling_phase_o,
    .bypass_switch_o, .ain_pchg_en_o, .ref_pos_pchg_en_o,
    .ref_neg_pchg_en_o, .common_mode_output_en_o,
    .common_mode_output_lvl_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk_sys_i);
      #1;
    end
  endtask

  // straps held through reset, then wait for the clock verdict
  task do_reset(input sel, input ser, input run);
    integer i;
    begin
      nrst_i = 1'b0;
      clk_sel_i = sel;
      ctrl_serial_i = ser;
      mclk_run = run;
      tick(5);
      nrst_i = 1'b1;
      i = 0;
      while (i < 300 && ext_clk_active_o !== 1'b1 && clk_err_o !== 1'b1) begin
        tick(1);
        i = i + 1;
      end
      if (i == 300) begin
        mismatches = mismatches + 1;
        finish_test;
      end
    end
  endtask

  task reg_wr(input [6:0] a, input [7:0] d);
    begin
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      tick(1);
      reg_wr_i = 1'b0;
      tick(2);
    end
  endtask

  task check_rd(input [6:0] a, input [7:0] e);
    begin
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      tick(1);
      reg_rd_i = 1'b0;
      tick(1);
      `CHK("reg_rdata_o", e, reg_rdata_o);
    end
  endtask

  task t_pin_good;
    integer i, tog, opn;
    reg     ph;
    begin
      do_reset(1'b0, 1'b0, 1'b1);
      `CHK("serial", 1'b0, serial_mode_o);
      `CHK("cmos", 1'b1, cmos_clk_sel_o);
      `CHK("conv", 1'b1, conv_en_o);
      `CHK("err", 1'b0, clk_err_o);
      `CHK("cm_lvl", 2'h0, common_mode_output_lvl_o);
      reg_wr(7'h11, 8'h00);
      `CHK("ain", 8'hFF, ain_pchg_en_o);
      check_rd(7'h16, 8'h02);
      ph = sampling_phase_o;
      i = 0;
      while (i < 100 && sampling_phase_o === ph) begin
        tick(1);
        i = i + 1;
      end
      if (i == 100) begin
        mismatches = mismatches + 1;
        finish_test;
      end
      tog = 0;
      opn = 0;
      ph = sampling_phase_o;
      repeat (320) begin
        tick(1);
        if (sampling_phase_o !== ph)
          tog = tog + 1;
        ph = sampling_phase_o;
        if (bypass_switch_o === 1'b0)
          opn = opn + 1;
      end
      `CHK("phases", 320 / (MDIV / 2 * MCLK_CYC), tog);
      `CHK("open", 320 / 4, opn);
      ch0_standby_i = 1'b1;
      tick(3);
      `CHK("cm_en", 1'b0, common_mode_output_en_o);
      ch0_standby_i = 1'b0;
      tick(3);
      `CHK("cm_en", 1'b1, common_mode_output_en_o);
    end
  endtask

  task t_serial_err;
    integer l;
    begin
      do_reset(1'b1, 1'b1, 1'b0);
      `CHK("hdr", 1'b1, hdr_clk_err_o);
      `CHK("conv", 1'b0, conv_en_o);
      `CHK("xtal", 1'b1, xtal_diff_sel_o);
      `CHK("ain", 8'hFF, ain_pchg_en_o);
      check_rd(7'h04, 8'h00);
      check_rd(7'h05, 8'h10);
      check_rd(7'h12, 8'h0F);
      check_rd(7'h13, 8'h00);
      check_rd(7'h14, 8'h00);
      check_rd(7'h16, 8'h0D);
      check_rd(7'h7F, 8'h00);
      for (l = 0; l < 4; l = l + 1) begin
        reg_wr(7'h05, 8'h10 | l[7:0]);
        `CHK("cm_lvl", l[1:0], common_mode_output_lvl_o);
      end
      reg_wr(7'h05, 8'h00);
      `CHK("cm_en", 1'b0, common_mode_output_en_o);
      reg_wr(7'h04, 8'h08);
      `CHK("lvds", 1'b1, lvds_en_o);
      reg_wr(7'h11, 8'hF5);
      reg_wr(7'h12, 8'hFA);
      `CHK("ain", 8'hA5, ain_pchg_en_o);
      check_rd(7'h11, 8'h05);
      reg_wr(7'h13, 8'hFF);
      reg_wr(7'h14, 8'h3C);
      `CHK("ref_pos", 8'hFF, ref_pos_pchg_en_o);
      `CHK("ref_neg", 8'h3C, ref_neg_pchg_en_o);
      reg_wr(7'h16, 8'h00);
      check_rd(7'h16, 8'h0D);
      mclk_run = 1'b1;
      tick(200);
      `CHK("err", 1'b1, clk_err_o);
      `CHK("ext", 1'b0, ext_clk_active_o);
    end
  endtask

  task t_serial_cmos;
    begin
      do_reset(1'b0, 1'b1, 1'b1);
      `CHK("ext", 1'b1, ext_clk_active_o);
      reg_wr(7'h04, 8'h08);
      `CHK("lvds", 1'b0, lvds_en_o);
      check_rd(7'h16, 8'h06);
    end
  endtask

  initial begin
    mismatches = 0;
    tests_run = 0;
    nrst_i = 1'b0;
    mclk_run = 1'b0;
    clk_sel_i = 1'b0;
    ctrl_serial_i = 1'b0;
    ch0_standby_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 7'h00;
    reg_wdata_i = 8'h00;
    t_pin_good;
    t_serial_err;
    t_serial_cmos;
    finish_test;
  end
endmodule

bind csfc_ctrl csfc_ctrl_props #(.STARTUP_CYC(STARTUP_CYC),
  .WIN_CYC(WIN_CYC)) csfc_ctrl_props_inst (.clk_sys_i, .nrst_i,
  .serial_mode_o, .ext_clk_active_o, .clk_err_o, .hdr_clk_err_o,
  .conv_en_o, .xtal_diff_sel_o, .lvds_en_o, .sampling_phase_o,
  .bypass_switch_o, .ain_pchg_en_o, .ref_pos_pchg_en_o,
  .ref_neg_pchg_en_o);
